// ==== pic_pkg.sv ====
package pic_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [15:0] PIC_OFS_EDGE  = 16'hfff2;
    localparam logic [15:0] PIC_OFS_ENA1  = 16'hfff3;
    localparam logic [15:0] PIC_OFS_ENA2  = 16'hfff4;
    localparam logic [15:0] PIC_OFS_REQ1  = 16'hfff6;
    localparam logic [15:0] PIC_OFS_REQ2  = 16'hfff7;
    localparam logic [15:0] PIC_OFS_WAKE  = 16'hfff9;
    localparam logic [15:0] PIC_OFS_CTRL  = 16'hfffc;

    localparam logic [7:0]  PIC_RST_EDGE  = 8'he0;
    localparam logic [7:0]  PIC_RST_ENA   = 8'h00;
    localparam logic [7:0]  PIC_RST_REQ1  = 8'h20;
    localparam logic [7:0]  PIC_RST_REQ2  = 8'h00;
    localparam logic [7:0]  PIC_RST_WAKE  = 8'h00;
    localparam logic [7:0]  PIC_EDGE_FIX  = 8'he0;
    localparam logic [7:0]  PIC_REQ1_FIX  = 8'h20;
    localparam int          PIC_MASK_BIT  = 0;
    localparam logic        PIC_RST_MASK  = 1'b1;

    // ****************************************
    // request-one / enable-one bit positions
    // ****************************************
    localparam int PIC_B_TA   = 7;
    localparam int PIC_B_S1   = 6;
    localparam int PIC_B_WP   = 5;
    // request-two / enable-two bit positions
    localparam int PIC_B_DT   = 7;
    localparam int PIC_B_AD   = 6;
    localparam int PIC_B_S2   = 5;
    localparam int PIC_B_TG   = 4;
    localparam int PIC_B_TFH  = 3;
    localparam int PIC_B_TFL  = 2;
    localparam int PIC_B_TC   = 1;
    localparam int PIC_B_TB   = 0;

    // ****************************************
    // vectors
    // ****************************************
    localparam int          PIC_NUM_EXT   = 13;
    localparam int          PIC_NUM_INT   = 20;
    localparam int          PIC_NUM_SLOT  = 17;
    localparam logic [4:0]  PIC_VEC_FIRST = 5'd4;
    localparam logic [15:0] PIC_VEC_SPAN  = 16'h0002;

    // peripheral pulse bundle (twenty internal sources)
    typedef struct packed {
        logic       s1_done;
        logic       ta_ovf;
        logic       tb_ovf;
        logic       tc_ovf;
        logic [1:0] tfl;
        logic [1:0] tfh;
        logic [1:0] tg;
        logic [1:0] s2;
        logic [5:0] s3;
        logic       ad_end;
        logic       direct;
    } pic_periph_t;

    // answer to the cpu
    typedef struct packed {
        logic        req;
        logic [4:0]  num;
        logic [15:0] addr;
    } pic_vector_t;

endpackage : pic_pkg

// ==== pic_edge_det.sv ====
`timescale 1ns/1ps
// two-stage synchroniser followed by a selectable edge detector
module pic_edge_det #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // pins and edge choice
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] rise_sel,
    // one-cycle edge pulses
    output logic      [WIDTH-1:0] edge_pulse
);
    import pic_pkg::*;

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] prev_r;

    // resets high so an idle high pin gives no false falling edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= '1;
            sync_r <= '1;
            prev_r <= '1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // only synchronised stages feed the detector
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_edge
            assign edge_pulse[g] = rise_sel[g] ? (sync_r[g] & ~prev_r[g])
                                               : (~sync_r[g] & prev_r[g]);
        end
    endgenerate

endmodule : pic_edge_det

// ==== pic_intc.sv ====
`timescale 1ns/1ps
module pic_intc (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // external request pins
    input  wire logic [4:0]           irq_pin,
    input  wire logic [7:0]           wakeup_pin,
    // internal peripheral pulses
    input  wire pic_pkg::pic_periph_t periph_evt,
    // cpu side
    input  wire logic                 cpu_busy,
    input  wire logic                 cpu_ack,
    input  wire logic                 mask_set,
    output pic_pkg::pic_vector_t      cpu_vec,
    output logic                      global_mask
);
    import pic_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [4:0]  edge_sel_r;
    logic [7:0]  ena1_r;
    logic [7:0]  ena2_r;
    logic [7:0]  req1_r;
    logic [7:0]  req2_r;
    logic [7:0]  wake_r;
    logic        mask_r;
    logic        s3_req_r;
    pic_vector_t vec_r;

    logic [4:0]  irq_edge;
    logic [7:0]  wake_edge;
    logic [7:0]  req1_set;
    logic [7:0]  req2_set;
    logic [16:0] slot_pend;
    logic        s3_any;
    logic        wr_en;
    logic        rd_en;
    logic        hit_edge;
    logic        hit_ena1;
    logic        hit_ena2;
    logic        hit_req1;
    logic        hit_req2;
    logic        hit_wake;
    logic        hit_ctrl;
    logic        addr_hit;
    logic [4:0]  win;
    logic [4:0]  vnum;

    // writes land in the access phase; reads are fetched in the setup cycle so
    // that prdata already stands when the access phase samples it
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    // ****************************************
    // address decode
    // ****************************************
    // one-hot register select built as a priority chain, so two offsets can
    // never hit together; an unmapped offset selects nothing
    always_comb begin
        hit_edge = 1'b0;
        hit_ena1 = 1'b0;
        hit_ena2 = 1'b0;
        hit_req1 = 1'b0;
        hit_req2 = 1'b0;
        hit_wake = 1'b0;
        hit_ctrl = 1'b0;
        if (paddr == PIC_OFS_EDGE) begin
            hit_edge = 1'b1;
        end else if (paddr == PIC_OFS_ENA1) begin
            hit_ena1 = 1'b1;
        end else if (paddr == PIC_OFS_ENA2) begin
            hit_ena2 = 1'b1;
        end else if (paddr == PIC_OFS_REQ1) begin
            hit_req1 = 1'b1;
        end else if (paddr == PIC_OFS_REQ2) begin
            hit_req2 = 1'b1;
        end else if (paddr == PIC_OFS_WAKE) begin
            hit_wake = 1'b1;
        end else if (paddr == PIC_OFS_CTRL) begin
            hit_ctrl = 1'b1;
        end
    end

    // any mapped register; the rest answer with an error
    assign addr_hit = hit_edge | hit_ena1 | hit_ena2 | hit_req1 |
                      hit_req2 | hit_wake | hit_ctrl;

    // ****************************************
    // pin front end
    // ****************************************
    pic_edge_det #(.WIDTH(5)) u_irq_edge (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_in     (irq_pin),
        .rise_sel   (edge_sel_r),
        .edge_pulse (irq_edge)
    );

    // wakeup pins are active low, so falling edges only
    pic_edge_det #(.WIDTH(8)) u_wake_edge (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_in     (wakeup_pin),
        .rise_sel   (8'h00),
        .edge_pulse (wake_edge)
    );

    // ****************************************
    // flag set terms
    // ****************************************
    always_comb begin
        req1_set           = {3'b000, irq_edge};
        req1_set[PIC_B_TA] = periph_evt.ta_ovf;
        req1_set[PIC_B_S1] = periph_evt.s1_done;
        req2_set           = 8'h00;
        req2_set[PIC_B_DT]  = periph_evt.direct;
        req2_set[PIC_B_AD]  = periph_evt.ad_end;
        req2_set[PIC_B_S2]  = |periph_evt.s2;
        req2_set[PIC_B_TG]  = |periph_evt.tg;
        req2_set[PIC_B_TFH] = |periph_evt.tfh;
        req2_set[PIC_B_TFL] = |periph_evt.tfl;
        req2_set[PIC_B_TC]  = periph_evt.tc_ovf;
        req2_set[PIC_B_TB]  = periph_evt.tb_ovf;
    end

    // ****************************************
    // registers
    // ****************************************
    // edge select: only bits 4..0 are stored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            edge_sel_r <= PIC_RST_EDGE[4:0];
        end else if (wr_en && paddr == PIC_OFS_EDGE) begin
            edge_sel_r <= pwdata[4:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ena1_r <= PIC_RST_ENA;
            ena2_r <= PIC_RST_ENA;
        end else begin
            if (wr_en && paddr == PIC_OFS_ENA1) begin
                ena1_r <= pwdata[7:0];
            end
            if (wr_en && paddr == PIC_OFS_ENA2) begin
                ena2_r <= pwdata[7:0];
            end
        end
    end

    // flags: a 0 write clears (except the fixed req1 bit 5), a same-cycle set wins, acceptance leaves them alone
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req1_r <= PIC_RST_REQ1;
            req2_r <= PIC_RST_REQ2;
            wake_r <= PIC_RST_WAKE;
        end else begin
            if (wr_en && paddr == PIC_OFS_REQ1) begin
                req1_r <= ((req1_r & pwdata[7:0]) | req1_set) | PIC_REQ1_FIX;
            end else begin
                req1_r <= req1_r | req1_set | PIC_REQ1_FIX;
            end
            if (wr_en && paddr == PIC_OFS_REQ2) begin
                req2_r <= (req2_r & pwdata[7:0]) | req2_set;
            end else begin
                req2_r <= req2_r | req2_set;
            end
            if (wr_en && paddr == PIC_OFS_WAKE) begin
                wake_r <= (wake_r & pwdata[7:0]) | wake_edge;
            end else begin
                wake_r <= wake_r | wake_edge;
            end
        end
    end

    // serial three keeps one sticky flag for all six sources; its control register lives outside,
    // so a software clear of this copy is via the control word bit 1
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s3_req_r <= 1'b0;
        end else if (wr_en && paddr == PIC_OFS_CTRL && pwdata[1]) begin
            s3_req_r <= |periph_evt.s3;                          // a same-cycle event wins
        end else begin
            s3_req_r <= s3_req_r | (|periph_evt.s3);
        end
    end
    assign s3_any = s3_req_r;

    // global mask: set by reset and by the cpu on acceptance; software clears
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask_r <= PIC_RST_MASK;
        end else if (mask_set) begin
            mask_r <= 1'b1;
        end else if (wr_en && paddr == PIC_OFS_CTRL) begin
            mask_r <= pwdata[PIC_MASK_BIT];
        end
    end
    assign global_mask = mask_r;

    // ****************************************
    // arbitration
    // ****************************************
    // slot index = vector number minus four, slot 0 highest
    always_comb begin
        slot_pend[4:0] = req1_r[4:0] & ena1_r[4:0];
        slot_pend[5]   = (|wake_r) & ena1_r[PIC_B_WP];
        slot_pend[6]   = req1_r[PIC_B_S1] & ena1_r[PIC_B_S1];
        slot_pend[7]   = req1_r[PIC_B_TA] & ena1_r[PIC_B_TA];
        slot_pend[8]   = req2_r[PIC_B_TB] & ena2_r[PIC_B_TB];
        slot_pend[9]   = req2_r[PIC_B_TC] & ena2_r[PIC_B_TC];
        slot_pend[10]  = req2_r[PIC_B_TFL] & ena2_r[PIC_B_TFL];
        slot_pend[11]  = req2_r[PIC_B_TFH] & ena2_r[PIC_B_TFH];
        slot_pend[12]  = req2_r[PIC_B_TG] & ena2_r[PIC_B_TG];
        slot_pend[13]  = req2_r[PIC_B_S2] & ena2_r[PIC_B_S2];
        slot_pend[14]  = s3_any;
        slot_pend[15]  = req2_r[PIC_B_AD] & ena2_r[PIC_B_AD];
        slot_pend[16]  = req2_r[PIC_B_DT] & ena2_r[PIC_B_DT];
    end

    // lowest set slot wins; returns slot count when none
    function automatic logic [4:0] pic_first(input logic [16:0] p);
        logic [4:0] idx;
        idx = 5'd17;
        for (int i = PIC_NUM_SLOT - 1; i >= 0; i--) begin
            if (p[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : pic_first

    // winner and its vector number; slot order is the fixed priority order,
    // so the highest pending source always maps to the lowest vector number
    always_comb begin
        win  = pic_first(slot_pend);
        vnum = win + PIC_VEC_FIRST;
    end

    // vector presented only when unmasked and the cpu can take it
    // flags are not cleared here: software clears a flag before it unmasks again
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vec_r <= '0;
        end else begin
            if (cpu_ack) begin
                vec_r.req <= 1'b0;
            end else if (!mask_r && !cpu_busy && !vec_r.req && win != 5'd17) begin
                vec_r.req  <= 1'b1;
                vec_r.num  <= vnum;
                vec_r.addr <= {10'h000, vnum, 1'b0};
            end else if (mask_r) begin
                vec_r.req <= 1'b0;
            end
        end
    end
    assign cpu_vec = vec_r;

    // ****************************************
    // apb read path
    // ****************************************
    // fetched on the setup edge; the value then stands until the next read setup
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (paddr == PIC_OFS_EDGE) begin
                prdata <= {24'h0, PIC_EDGE_FIX[7:5], edge_sel_r};
            end else if (paddr == PIC_OFS_ENA1) begin
                prdata <= {24'h0, ena1_r};
            end else if (paddr == PIC_OFS_ENA2) begin
                prdata <= {24'h0, ena2_r};
            end else if (paddr == PIC_OFS_REQ1) begin
                prdata <= {24'h0, req1_r};
            end else if (paddr == PIC_OFS_REQ2) begin
                prdata <= {24'h0, req2_r};
            end else if (paddr == PIC_OFS_WAKE) begin
                prdata <= {24'h0, wake_r};
            end else if (paddr == PIC_OFS_CTRL) begin
                prdata <= {30'h0, s3_any, mask_r};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // single wait-free access phase; unmapped addresses flag an error
    // no wait states: every register answers in the access phase itself
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;

endmodule : pic_intc

// ==== pic_intc_asserts.sv ====
`timescale 1ns/1ps
// ****************************************
// vector and mask checks at the top ports
// ****************************************
module pic_intc_asserts (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rst,
    // apb controls
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [15:0]          paddr,
    // cpu side
    input wire logic                 cpu_busy,
    input wire logic                 cpu_ack,
    input wire logic                 mask_set,
    input wire pic_pkg::pic_vector_t cpu_vec,
    input wire logic                 global_mask
);
    import pic_pkg::*;
    logic ctrl_wr;
    // only a software write to the control word may lower the mask
    assign ctrl_wr = psel && penable && pwrite && (paddr == PIC_OFS_CTRL);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_taken;
        cpu_vec.req && cpu_ack;
    endsequence
    sequence s_standing;
        cpu_vec.req && !cpu_ack && !mask_set && !global_mask;
    endsequence
    a_vec_address: assert property (
        cpu_vec.req |-> cpu_vec.addr ==
            16'h0008 + PIC_VEC_SPAN * 16'(cpu_vec.num - PIC_VEC_FIRST))
        else $error("vector address does not follow vector number");
    a_vec_range: assert property (
        cpu_vec.req |-> cpu_vec.num inside {[5'd4:5'd20]})
        else $error("vector number outside the legal range");
    a_mask_blocks: assert property (global_mask |=> !$rose(cpu_vec.req))
        else $error("vector raised while masked");
    a_busy_defers: assert property (cpu_busy |=> !$rose(cpu_vec.req))
        else $error("vector raised while cpu busy");
    a_ack_drops: assert property (s_taken |=> !cpu_vec.req)
        else $error("vector request kept after ack");
    a_entry_masks: assert property (mask_set |=> global_mask)
        else $error("exception entry did not set the mask");
    a_mask_holds: assert property (global_mask && !ctrl_wr |=> global_mask)
        else $error("mask dropped without a software write");
    a_vec_stands: assert property (
        s_standing |=> global_mask || (cpu_vec.req && $stable(cpu_vec)))
        else $error("pending vector changed before ack");
endmodule : pic_intc_asserts

bind pic_intc pic_intc_asserts u_pic_intc_asserts (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .cpu_busy, .cpu_ack, .mask_set, .cpu_vec, .global_mask
);

// ==== pic_cpu_model.sv ====
`timescale 1ns/1ps
// ****************************************
// cpu core model: takes vectors, enters exceptions
// ****************************************
module pic_cpu_model (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // vector in and answer delay
    input  wire pic_pkg::pic_vector_t cpu_vec,
    input  wire logic [3:0]           ack_delay,
    // handshake out
    output logic                      cpu_busy,
    output logic                      cpu_ack,
    output logic                      mask_set,
    // record of taken vectors
    output logic [4:0]                taken_num,
    output logic [7:0]                taken_cnt
);
    import pic_pkg::*;
    logic [3:0] wait_r;
    logic [1:0] busy_r;
    // waits out the delay, then acks; a one-cycle ack avoids double takes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_r    <= 4'h0;
            cpu_ack   <= 1'b0;
            taken_num <= 5'h00;
            taken_cnt <= 8'h00;
        end else begin
            cpu_ack <= 1'b0;
            if (cpu_vec.req && !cpu_ack) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r >= ack_delay) begin
                    cpu_ack   <= 1'b1;
                    wait_r    <= 4'h0;
                    taken_num <= cpu_vec.num;
                    taken_cnt <= taken_cnt + 8'h01;
                end
            end
        end
    end
    assign mask_set = cpu_ack; // entry masks in the same cycle as the ack
    // stays busy a few cycles after entry, like a stacking sequence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) busy_r <= 2'h0;
        else if (cpu_ack) busy_r <= 2'h3;
        else if (busy_r != 2'h0) busy_r <= busy_r - 2'h1;
    end
    assign cpu_busy = cpu_ack || (busy_r != 2'h0);
endmodule : pic_cpu_model

// ==== pic_intc_tb.sv ====
`timescale 1ns/1ps
module pic_intc_tb;
    import pic_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic        cpu_busy, cpu_ack, mask_set, global_mask;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  irq_pin, taken_num;
    logic [7:0]  wakeup_pin, taken_cnt, n0;
    logic [3:0]  ack_delay;
    logic [7:0]  sh [3];
    logic [15:0] ofs [3];
    pic_periph_t periph_evt;
    pic_vector_t cpu_vec;
    int          n_fail, num_checks, k, b;

    pic_intc u_pic_intc (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_pin, .wakeup_pin, .periph_evt, .cpu_busy,
        .cpu_ack, .mask_set, .cpu_vec, .global_mask);
    pic_cpu_model u_pic_cpu_model (.clk_sys, .rst, .cpu_vec, .ack_delay, .cpu_busy,
        .cpu_ack, .mask_set, .taken_num, .taken_cnt);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; a spare cycle after it keeps psel from two drives at once
    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic exp_rd(input logic [15:0] a, input logic [7:0] d, input logic err);
        logic [7:0] q;
        logic       e;
        apb(1'b0, a, 8'h00, q, e);
        check(q, d);
        check(e, err);
    endtask : exp_rd

    task automatic summarize;
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    // watchdog: the whole run needs well under 5000 cycles
    initial begin
        #100us;
        n_fail++;
        summarize();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        irq_pin = 5'h1f;
        wakeup_pin = 8'hff;
        periph_evt = '0;
        ack_delay = 4'h0;
        n_fail = 0;
        num_checks = 0;
        sh = '{8'hff, 8'hff, 8'hff};
        ofs = '{PIC_OFS_REQ1, PIC_OFS_REQ2, PIC_OFS_WAKE};
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // reset state and register table
        check(global_mask, 1'b1);
        exp_rd(16'hfff2, 8'he0, 1'b0);
        exp_rd(16'hfff3, 8'h00, 1'b0);
        exp_rd(16'hfff4, 8'h00, 1'b0);
        exp_rd(16'hfff6, 8'h20, 1'b0);
        exp_rd(16'hfff7, 8'h00, 1'b0);
        exp_rd(16'hfff9, 8'h00, 1'b0);
        exp_rd(16'hfff5, 8'h00, 1'b1);
        // reserved edge bits stay 1
        wr(PIC_OFS_EDGE, 8'h00);
        exp_rd(PIC_OFS_EDGE, 8'he0, 1'b0);
        wr(PIC_OFS_EDGE, 8'h0a);
        exp_rd(PIC_OFS_EDGE, 8'hea, 1'b0);
        // falling edges reach pins 0, 2, 4 only
        irq_pin <= 5'h00;
        repeat (8) @(posedge clk_sys);
        wr(PIC_OFS_REQ1, 8'hff);
        exp_rd(PIC_OFS_REQ1, 8'h35, 1'b0);
        // unmasked but disabled flags give no vector
        wr(PIC_OFS_CTRL, 8'h00);
        repeat (10) @(posedge clk_sys);
        check(cpu_vec.req, 1'b0);
        wr(PIC_OFS_CTRL, 8'h01);
        wr(PIC_OFS_REQ1, 8'h00);
        exp_rd(PIC_OFS_REQ1, 8'h20, 1'b0);
        // rising edges reach pins 1 and 3
        irq_pin <= 5'h1f;
        repeat (8) @(posedge clk_sys);
        exp_rd(PIC_OFS_REQ1, 8'h2a, 1'b0);
        wr(PIC_OFS_REQ1, 8'h00);
        wr(PIC_OFS_EDGE, 8'h00);
        wr(PIC_OFS_ENA1, 8'hff);
        wr(PIC_OFS_ENA2, 8'hff);
        exp_rd(PIC_OFS_ENA2, 8'hff, 1'b0);
        // every source at once while masked
        irq_pin <= 5'h00;
        wakeup_pin <= 8'h00;
        periph_evt <= '1;
        @(posedge clk_sys);
        periph_evt <= '0;
        repeat (8) @(posedge clk_sys);
        check(cpu_vec.req, 1'b0);
        exp_rd(PIC_OFS_REQ1, 8'hff, 1'b0);
        exp_rd(PIC_OFS_REQ2, 8'hff, 1'b0);
        exp_rd(PIC_OFS_WAKE, 8'hff, 1'b0);
        // vectors must come out in priority order, prompt and slow cpu alike
        for (int v = 4; v <= 20; v++) begin
            n0 = taken_cnt;
            ack_delay <= v[0] ? 4'h5 : 4'h0;
            wr(PIC_OFS_CTRL, 8'h00);
            for (int t = 0; t < 60 && taken_cnt === n0; t++) @(posedge clk_sys);
            check(taken_cnt, n0 + 8'h01);
            check(taken_num, v[4:0]);
            check(cpu_vec.addr, 32'h0008 + 32'(2 * (v - 4)));
            if (v == 18) begin
                exp_rd(PIC_OFS_CTRL, 8'h03, 1'b0);
                wr(PIC_OFS_CTRL, 8'h03);
            end else begin
                k = (v == 9) ? 2 : ((v < 12) ? 0 : 1);
                b = (v < 12) ? v - 4 : ((v > 18) ? v - 13 : v - 12);
                exp_rd(ofs[k], sh[k], 1'b0);
                sh[k] = (k == 2) ? 8'h00 : (sh[k] & ~(8'h01 << b));
                wr(ofs[k], sh[k]);
            end
        end
        wr(PIC_OFS_CTRL, 8'h00);
        repeat (10) @(posedge clk_sys);
        check(cpu_vec.req, 1'b0);
        // pins 4 and 0 on rising edges while masked, then a reset in mid-run
        wr(PIC_OFS_CTRL, 8'h01);
        wr(PIC_OFS_EDGE, 8'h11);
        irq_pin <= 5'h1f;
        wakeup_pin <= 8'hff;
        repeat (8) @(posedge clk_sys);
        exp_rd(PIC_OFS_REQ1, 8'h31, 1'b0);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check(global_mask, 1'b1);
        check(cpu_vec.req, 1'b0);
        exp_rd(PIC_OFS_EDGE, 8'he0, 1'b0);
        exp_rd(PIC_OFS_REQ1, 8'h20, 1'b0);
        summarize();
    end
endmodule : pic_intc_tb
